//--- bench/pusr_pin_model.sv
// model of the board side: interrupt source and pin readback levels
`timescale 1ns/10ps
module pusr_pin_model (
  input wire clk_in,
  output logic int_pin_out,
  output logic clk_div_out,
  output logic [2:0] gp_level_out
);
  initial begin
    int_pin_out = 1'b0;
    clk_div_out = 1'b0;
  end
  // readback pattern changes every cycle so a sample an odd number of cycles stale never matches
  always @(posedge clk_in) begin
    clk_div_out <= ~clk_div_out;
  end
  assign gp_level_out = {clk_div_out, ~clk_div_out, clk_div_out};
  task automatic set_int(input logic v);
    @(posedge clk_in);
    int_pin_out <= v;
  endtask
endmodule // pusr_pin_model

//--- bench/pusr_settings_readback_asserts.sv
// checker for the settings readback block ports
`timescale 1ns/10ps
module pusr_settings_readback_asserts (
  input wire ref_clk_in,
  input wire resetn_in,
  input wire avs_waitrequest_out,
  input wire avs_write_in,
  input wire [1:0] adc_ref_sel_out,
  input wire adc_ref_on_out,
  input wire [8:0] cfg_max_ma_out,
  input wire [7:0] resp_byte_out,
  input wire [5:0] resp_index_out,
  input wire resp_valid_out,
  input wire resp_last_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_first;
    resp_valid_out && resp_index_out == 6'h00;
  endsequence
  sequence s_chip_len;
    resp_valid_out && resp_index_out == 6'h02 && resp_byte_out == 8'h0E;
  endsequence
  sequence s_final;
    resp_valid_out && resp_last_out && resp_index_out == 6'h3F;
  endsequence
  a_echo_byte: assert property (s_first |-> resp_byte_out == 8'hB0)
    else $error("reply byte 0 is not the command echo");
  a_done_code: assert property (resp_valid_out && resp_index_out == 6'h01 |->
    resp_byte_out == 8'h00)
    else $error("reply byte 1 is not the success code");
  a_reply_span: assert property (s_first |-> ##63 s_final)
    else $error("reply does not end 63 cycles after byte 0");
  a_index_step: assert property (resp_valid_out && !resp_last_out |=>
    resp_valid_out && resp_index_out == $past(resp_index_out) + 6'h01)
    else $error("reply index did not advance by one");
  a_tail_zero: assert property (resp_valid_out && resp_index_out > 6'h0D |->
    resp_byte_out == 8'h00)
    else $error("reply tail byte not zero");
  a_last_flag: assert property (resp_last_out |-> s_final)
    else $error("last flag off the final index");
  a_adc_off: assert property (adc_ref_on_out == (adc_ref_sel_out != 2'h0))
    else $error("adc reference enable disagrees with code");
  a_ma_even: assert property (cfg_max_ma_out[0] == 1'b0)
    else $error("requested current is not a doubled byte");
  a_ma_double: assert property (s_chip_len |-> ##11 resp_byte_out == cfg_max_ma_out[8:1])
    else $error("requested current is not twice reply byte 13");
  a_wait_once: assert property (avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("read held off for more than one cycle");
  a_write_nowait: assert property (avs_write_in |-> !avs_waitrequest_out)
    else $error("write was held off");
endmodule // pusr_settings_readback_asserts
bind pusr_settings_readback pusr_settings_readback_asserts pusr_settings_readback_asserts_i (
  .ref_clk_in, .resetn_in, .avs_waitrequest_out, .avs_write_in, .adc_ref_sel_out, .adc_ref_on_out,
  .cfg_max_ma_out, .resp_byte_out, .resp_index_out, .resp_valid_out, .resp_last_out);

//--- bench/test_pusr_settings_readback.sv
// self-checking bench for the settings readback block
`timescale 1ns/10ps
module test_pusr_settings_readback;
  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [5:0] avs_address_in = 6'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] src = 4'h0;
  wire [31:0] avs_readdata_out;
  wire avs_waitrequest_out, irq_out, int_pin, clk_div, int_flag_out;
  wire [2:0] gp_level, gp_pin_out, gp_pin_oe_out, gp_analog_out;
  wire [1:0] adc_ref_sel_out;
  wire adc_ref_on_out, dac_ref_supply_out, resp_valid_out, resp_last_out;
  wire [7:0] cfg_power_attr_out, resp_byte_out;
  wire [8:0] cfg_max_ma_out;
  wire [5:0] resp_index_out;
  int errors = 0;
  int total_checks = 0;
  logic [31:0] q;
  logic [7:0] e [64];
  always #2 ref_clk_in = ~ref_clk_in;
  pusr_pin_model pusr_pin_model_i (.clk_in(ref_clk_in), .int_pin_out(int_pin),
    .clk_div_out(clk_div), .gp_level_out(gp_level));
  pusr_settings_readback pusr_settings_readback_i (.ref_clk_in, .resetn_in, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in(4'hF),
    .avs_readdata_out, .avs_waitrequest_out, .irq_out, .int_pin_in(int_pin),
    .suspend_in(src[0]), .usb_configured_in(src[1]),
    .rx_active_in(src[2]), .tx_active_in(src[3]),
    .clk_div_in(clk_div), .gp_pin_in(gp_level), .gp_pin_out, .gp_pin_oe_out, .gp_analog_out,
    .adc_ref_sel_out, .adc_ref_on_out, .dac_ref_supply_out, .cfg_power_attr_out,
    .cfg_max_ma_out, .int_flag_out, .resp_byte_out, .resp_index_out, .resp_valid_out,
    .resp_last_out);
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic fail(input string m);
    errors++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      fail($sformatf("%s got %h exp %h", m, got, exp));
    end
  endtask
  // read data are taken at the edge where waitrequest is seen low
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [31:0] d);
    int n;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= rd;
    avs_write_in <= !rd;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50) begin
      fail("bus timeout");
      tally_and_finish();
    end
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    xfer(1'b1, a, 32'h0);
    chk(q, exp, "register read");
  endtask
  task automatic reply(input logic [31:0] cmd);
    logic [7:0] got [64];
    int n;
    xfer(1'b0, 6'h00, cmd);
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
      if (resp_valid_out === 1'b1) got[resp_index_out] = resp_byte_out;
    end while (resp_last_out !== 1'b1 && n < 100);
    if (n >= 100) fail("reply timeout");
    for (int i = 0; i < 64; i++) chk(got[i], e[i], $sformatf("reply byte %0d", i));
  endtask
  task automatic edge_case(input logic [7:0] cfg, input logic lvl, input logic exp);
    xfer(1'b0, 6'h04, {24'h0, cfg});
    xfer(1'b0, 6'h00, 32'h4);
    xfer(1'b0, 6'h18, 32'h1);
    pusr_pin_model_i.set_int(lvl);
    repeat (8) @(posedge ref_clk_in);
    chk(irq_out, exp, "irq after pin edge");
    chk(int_flag_out, exp, "interrupt flag");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    rd_chk(6'h04, 32'h0);
    rd_chk(6'h10, 32'h3280);
    rd_chk(6'h14, 32'h080808);
    rd_chk(6'h3C, 32'h0);
    chk(cfg_max_ma_out, 32'h64, "reset current");
    $display("test reset values done");
    xfer(1'b0, 6'h04, 32'hF7);
    xfer(1'b0, 6'h08, 32'h1234);
    xfer(1'b0, 6'h0C, 32'hABCD);
    xfer(1'b0, 6'h10, 32'h2DC0);
    e = '{default: 8'h00};
    e[0] = 8'hB0;
    e[2] = 8'h0E;
    e[7] = 8'h74;
    {e[9], e[8], e[11], e[10], e[12], e[13]} = 48'h1234ABCDC02D;
    reply(32'h5);
    rd_chk(6'h18, 32'h2);
    chk(cfg_power_attr_out, 32'hC0, "power attributes");
    chk(cfg_max_ma_out, 32'h5A, "requested current");
    chk(dac_ref_supply_out, 32'h1, "dac reference");
    $display("test chip reply done");
    for (int c = 0; c < 4; c++) begin
      xfer(1'b0, 6'h04, c << 3);
      xfer(1'b0, 6'h00, 32'h4);
      chk(adc_ref_sel_out, c, "adc reference code");
      chk(adc_ref_on_out, c != 0, "adc reference on");
      chk(dac_ref_supply_out, 32'h0, "dac reference");
    end
    $display("test adc codes done");
    xfer(1'b0, 6'h14, 32'h1B0AF0);
    e = '{default: 8'h00};
    {e[0], e[2], e[4], e[5], e[6]} = 40'hB008100A1B;
    reply(32'h2);
    xfer(1'b0, 6'h00, 32'h4);
    chk(gp_pin_out[0], 32'h1, "pin zero level");
    chk(gp_pin_oe_out[1:0], 32'h1, "pin drive enables");
    chk(gp_analog_out, 32'h6, "analog pins");
    src <= 4'h3;
    xfer(1'b0, 6'h14, 32'h010101);
    repeat (4) @(posedge ref_clk_in);
    chk(gp_pin_oe_out, 32'h7, "alternate pins driven");
    chk({gp_pin_out[2], gp_pin_out[0]}, 32'h3, "suspend and configured pins");
    src <= 4'hC;
    xfer(1'b0, 6'h14, 32'h000302);
    repeat (4) @(posedge ref_clk_in);
    chk(gp_pin_out, 32'h3, "activity led pins");
    chk(gp_pin_oe_out, 32'h7, "led and output pins");
    xfer(1'b0, 6'h14, 32'h000400);
    repeat (2) @(posedge ref_clk_in);
    chk(gp_pin_oe_out, 32'h5, "interrupt pin undriven");
    $display("test pin setup done");
    xfer(1'b0, 6'h18, 32'h3);
    xfer(1'b0, 6'h1C, 32'h1);
    edge_case(8'h20, 1'b1, 1'b1);
    edge_case(8'h20, 1'b0, 1'b0);
    edge_case(8'h40, 1'b1, 1'b0);
    edge_case(8'h40, 1'b0, 1'b1);
    xfer(1'b0, 6'h1C, 32'h0);
    chk(irq_out, 32'h0, "masked irq");
    xfer(1'b1, 6'h24, 32'h0);
    chk(q[2:0], 32'h4, "state register");
    $display("test interrupt edges done");
    tally_and_finish();
  end
endmodule // test_pusr_settings_readback

//--- design/pusr_regs.vh
// register offsets, field positions, reset values and codes for the settings readback block
`ifndef PUSR_REGS_VH
`define PUSR_REGS_VH
// avalon word offsets (byte addresses)
`define PUSR_CTRL_ADDR 6'h00
`define PUSR_CHIP_ADDR 6'h04
`define PUSR_VID_ADDR 6'h08
`define PUSR_PID_ADDR 6'h0C
`define PUSR_POWER_ADDR 6'h10
`define PUSR_GP_ADDR 6'h14
`define PUSR_STATUS_ADDR 6'h18
`define PUSR_MASK_ADDR 6'h1C
`define PUSR_RESP_ADDR 6'h20
`define PUSR_STATE_ADDR 6'h24
// ctrl register bits
`define PUSR_CTRL_CHIP_BIT 0
`define PUSR_CTRL_GP_BIT 1
`define PUSR_CTRL_APPLY_BIT 2
// status / mask bits
`define PUSR_ST_IRQ_BIT 0
`define PUSR_ST_DONE_BIT 1
// chip settings byte 7 fields
`define PUSR_NEG_EDGE_BIT 6
`define PUSR_POS_EDGE_BIT 5
`define PUSR_ADC_REF_HI 4
`define PUSR_ADC_REF_LO 3
`define PUSR_DAC_REF_BIT 2
// gp byte fields
`define PUSR_GP_OUT_BIT 4
`define PUSR_GP_DIR_BIT 3
// response constants
`define PUSR_CMD_ECHO 8'hB0
`define PUSR_DONE_OK 8'h00
`define PUSR_RESP_LAST 6'h3F
`define PUSR_CHIP_LEN 8'h0E
`define PUSR_GP_LEN 8'h08
// reset values of stored settings
`define PUSR_CHIP7_RST 8'h00
`define PUSR_VID_RST 16'h0000
`define PUSR_PID_RST 16'h0000
`define PUSR_ATTR_RST 8'h80
`define PUSR_MA_RST 8'h32
`define PUSR_GP_RST 24'h080808
// adc reference codes
`define PUSR_ADC_OFF 2'h0
`define PUSR_ADC_1V024 2'h1
`define PUSR_ADC_2V048 2'h2
`define PUSR_ADC_4V096 2'h3
`endif

//--- design/pusr_settings_readback.v
// power-up settings readback: response builder, pin mux and edge detect
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "pusr_regs.vh"
module pusr_settings_readback (
  // clock and reset
  input wire ref_clk_in,
  input wire resetn_in,
  // avalon-mm slave
  input wire [5:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  output wire irq_out,
  // pin sources
  input wire int_pin_in,
  input wire suspend_in,
  input wire usb_configured_in,
  input wire rx_active_in,
  input wire tx_active_in,
  input wire clk_div_in,
  input wire [2:0] gp_pin_in,
  // pin drive
  output reg [2:0] gp_pin_out,
  output reg [2:0] gp_pin_oe_out,
  output reg [2:0] gp_analog_out,
  // analog, usb config and interrupt flag
  output reg [1:0] adc_ref_sel_out,
  output reg adc_ref_on_out,
  output reg dac_ref_supply_out,
  output reg [7:0] cfg_power_attr_out,
  output reg [8:0] cfg_max_ma_out,
  output reg int_flag_out,
  // response byte stream
  output reg [7:0] resp_byte_out,
  output reg [5:0] resp_index_out,
  output reg resp_valid_out,
  output reg resp_last_out
);

  localparam ST_IDLE = 2'h0;
  localparam ST_CHIP = 2'h1;
  localparam ST_GP = 2'h2;

  reg [7:0] chip7;
  reg [15:0] vid;
  reg [15:0] pid;
  reg [7:0] attr;
  reg [7:0] ma;
  reg [23:0] gp_cfg;
  reg [1:0] status;
  reg [1:0] mask;
  reg [1:0] state;
  reg [5:0] idx;
  reg rd_done;
  reg int_s1, int_s2, int_s3;
  reg [2:0] gin_s1, gin_s2;
  reg sus_s1, sus_s2, usb_s1, usb_s2, rx_s1, rx_s2, tx_s1, tx_s2, clk_s1, clk_s2;
  reg [7:0] next_byte;
  reg [2:0] next_pin;
  reg [2:0] next_oe;
  reg [2:0] next_an;
  wire wr = avs_write_in;
  wire edge_hit;
  wire done_evt;

  // --------------------------------------------------------------------
  // bus slave
  // --------------------------------------------------------------------
  // reads hold off one edge so the registered read data stand at acceptance;
  // writes never wait
  assign avs_waitrequest_out = avs_read_in && !rd_done;
  assign irq_out = |(status & mask);

  function [31:0] merge;
    input [31:0] old;
    input [31:0] val;
    input [3:0] be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge[i*8 +: 8] = val[i*8 +: 8];
        end
      end
    end
  endfunction

  function [7:0] gp_byte;
    input [7:0] raw;
    begin
      gp_byte = {3'h0, raw[4:0]};
    end
  endfunction

  wire [31:0] m_chip = merge({24'h0, chip7}, avs_writedata_in, avs_byteenable_in);
  wire [31:0] m_vid = merge({16'h0, vid}, avs_writedata_in, avs_byteenable_in);
  wire [31:0] m_pid = merge({16'h0, pid}, avs_writedata_in, avs_byteenable_in);
  wire [31:0] m_pow = merge({16'h0, ma, attr}, avs_writedata_in, avs_byteenable_in);
  wire [31:0] m_gp = merge({8'h0, gp_cfg}, avs_writedata_in, avs_byteenable_in);
  wire [31:0] m_mask = merge({30'h0, mask}, avs_writedata_in, avs_byteenable_in);
  wire [31:0] w1c = avs_byteenable_in[0] ? avs_writedata_in : 32'h0;

  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      chip7 <= `PUSR_CHIP7_RST;
      vid <= `PUSR_VID_RST;
      pid <= `PUSR_PID_RST;
      attr <= `PUSR_ATTR_RST;
      ma <= `PUSR_MA_RST;
      gp_cfg <= `PUSR_GP_RST;
      mask <= 2'h0;
      status <= 2'h0;
    end else begin
      if (wr && avs_address_in == `PUSR_CHIP_ADDR) begin
        chip7 <= m_chip[7:0];
      end
      if (wr && avs_address_in == `PUSR_VID_ADDR) begin
        vid <= m_vid[15:0];
      end
      if (wr && avs_address_in == `PUSR_PID_ADDR) begin
        pid <= m_pid[15:0];
      end
      if (wr && avs_address_in == `PUSR_POWER_ADDR) begin
        attr <= m_pow[7:0];
        ma <= m_pow[15:8];
      end
      if (wr && avs_address_in == `PUSR_GP_ADDR) begin
        gp_cfg <= m_gp[23:0];
      end
      if (wr && avs_address_in == `PUSR_MASK_ADDR) begin
        mask <= m_mask[1:0];
      end
      // set wins over write-one-to-clear
      status <= (status & ~((wr && avs_address_in == `PUSR_STATUS_ADDR) ? w1c[1:0] : 2'h0))
        | {done_evt, edge_hit};
    end
  end

  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      rd_done <= 1'b0;
    end else begin
      rd_done <= avs_read_in && !rd_done;
    end
  end

  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      avs_readdata_out <= 32'h0;
    end else if (avs_read_in && !rd_done) begin
      case (avs_address_in)
        `PUSR_CHIP_ADDR: avs_readdata_out <= {24'h0, chip7};
        `PUSR_VID_ADDR: avs_readdata_out <= {16'h0, vid};
        `PUSR_PID_ADDR: avs_readdata_out <= {16'h0, pid};
        `PUSR_POWER_ADDR: avs_readdata_out <= {16'h0, ma, attr};
        `PUSR_GP_ADDR: avs_readdata_out <= {8'h0, gp_cfg};
        `PUSR_STATUS_ADDR: avs_readdata_out <= {30'h0, status};
        `PUSR_MASK_ADDR: avs_readdata_out <= {30'h0, mask};
        `PUSR_RESP_ADDR: avs_readdata_out <= {17'h0, resp_valid_out, resp_index_out, resp_byte_out};
        // synchronised pin levels are only visible here, for software readback
        `PUSR_STATE_ADDR: avs_readdata_out <= {26'h0, gin_s2, int_flag_out, state};
        default: avs_readdata_out <= 32'h0;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // input synchronisers and interrupt edge detection
  // --------------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      int_s1 <= 1'b0;
      int_s2 <= 1'b0;
      int_s3 <= 1'b0;
      gin_s1 <= 3'h0;
      gin_s2 <= 3'h0;
      {sus_s1, sus_s2, usb_s1, usb_s2, rx_s1, rx_s2, tx_s1, tx_s2, clk_s1, clk_s2} <= 10'h000;
    end else begin
      int_s1 <= int_pin_in;
      int_s2 <= int_s1;
      int_s3 <= int_s2;
      gin_s1 <= gp_pin_in;
      gin_s2 <= gin_s1;
      sus_s1 <= suspend_in;
      sus_s2 <= sus_s1;
      usb_s1 <= usb_configured_in;
      usb_s2 <= usb_s1;
      rx_s1 <= rx_active_in;
      rx_s2 <= rx_s1;
      tx_s1 <= tx_active_in;
      tx_s2 <= tx_s1;
      clk_s1 <= clk_div_in;
      clk_s2 <= clk_s1;
    end
  end

  // the interrupt pin is sampled through the synchroniser, so pulses
  // shorter than a clock period may be missed
  assign edge_hit = (chip7[`PUSR_NEG_EDGE_BIT] && int_s3 && !int_s2)
    || (chip7[`PUSR_POS_EDGE_BIT] && !int_s3 && int_s2);

  // --------------------------------------------------------------------
  // analog, usb config and interrupt flag
  // --------------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      adc_ref_sel_out <= `PUSR_ADC_OFF;
      adc_ref_on_out <= 1'b0;
      dac_ref_supply_out <= 1'b0;
      cfg_power_attr_out <= 8'h00;
      cfg_max_ma_out <= 9'h000;
      int_flag_out <= 1'b0;
    end else begin
      adc_ref_sel_out <= chip7[`PUSR_ADC_REF_HI:`PUSR_ADC_REF_LO];
      adc_ref_on_out <= chip7[`PUSR_ADC_REF_HI:`PUSR_ADC_REF_LO] != `PUSR_ADC_OFF;
      dac_ref_supply_out <= chip7[`PUSR_DAC_REF_BIT];
      cfg_power_attr_out <= attr;
      cfg_max_ma_out <= {ma, 1'b0};
      // flag held until cleared through the status register
      int_flag_out <= status[`PUSR_ST_IRQ_BIT] | edge_hit;
    end
  end

  // --------------------------------------------------------------------
  // pin mux
  // --------------------------------------------------------------------
  // don't-care designation codes leave the pin undriven, so a stray code
  // never fights whatever else sits on the board net
  always @* begin
    next_pin = 3'h0;
    next_oe = 3'h0;
    next_an = 3'h0;
    case (gp_cfg[2:0])
      3'h0: begin
        next_pin[0] = gp_cfg[`PUSR_GP_OUT_BIT];
        next_oe[0] = !gp_cfg[`PUSR_GP_DIR_BIT];
      end
      3'h1: begin
        next_pin[0] = sus_s2;
        next_oe[0] = 1'b1;
      end
      3'h2: begin
        next_pin[0] = rx_s2;
        next_oe[0] = 1'b1;
      end
      default: next_oe[0] = 1'b0;
    endcase
    case (gp_cfg[10:8])
      3'h0: begin
        next_pin[1] = gp_cfg[8+`PUSR_GP_OUT_BIT];
        next_oe[1] = !gp_cfg[8+`PUSR_GP_DIR_BIT];
      end
      3'h1: begin
        next_pin[1] = clk_s2;
        next_oe[1] = 1'b1;
      end
      3'h2: next_an[1] = 1'b1;
      3'h3: begin
        next_pin[1] = tx_s2;
        next_oe[1] = 1'b1;
      end
      3'h4: next_oe[1] = 1'b0;
      default: next_oe[1] = 1'b0;
    endcase
    case (gp_cfg[18:16])
      3'h0: begin
        next_pin[2] = gp_cfg[16+`PUSR_GP_OUT_BIT];
        next_oe[2] = !gp_cfg[16+`PUSR_GP_DIR_BIT];
      end
      3'h1: begin
        next_pin[2] = usb_s2;
        next_oe[2] = 1'b1;
      end
      3'h2: next_an[2] = 1'b1;
      3'h3: next_an[2] = 1'b1;
      default: next_oe[2] = 1'b0;
    endcase
  end

  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      gp_pin_out <= 3'h0;
      gp_pin_oe_out <= 3'h0;
      gp_analog_out <= 3'h0;
    end else begin
      gp_pin_out <= next_pin;
      gp_pin_oe_out <= next_oe;
      gp_analog_out <= next_an;
    end
  end

  // --------------------------------------------------------------------
  // response builder
  // --------------------------------------------------------------------
  always @* begin
    next_byte = 8'h00;
    // bytes 4 to 13 are gated by the reply kind, so the other reply's fields read zero
    case (idx)
      6'h00: next_byte = `PUSR_CMD_ECHO;
      6'h01: next_byte = `PUSR_DONE_OK;
      6'h02: next_byte = (state == ST_CHIP) ? `PUSR_CHIP_LEN : `PUSR_GP_LEN;
      6'h04: next_byte = (state == ST_GP) ? gp_byte(gp_cfg[7:0]) : 8'h00;
      6'h05: next_byte = (state == ST_GP) ? gp_byte(gp_cfg[15:8]) : 8'h00;
      6'h06: next_byte = (state == ST_GP) ? gp_byte(gp_cfg[23:16]) : 8'h00;
      6'h07: next_byte = (state == ST_CHIP) ? {1'b0, chip7[6:2], 2'b00} : 8'h00;
      6'h08: next_byte = (state == ST_CHIP) ? vid[7:0] : 8'h00;
      6'h09: next_byte = (state == ST_CHIP) ? vid[15:8] : 8'h00;
      6'h0A: next_byte = (state == ST_CHIP) ? pid[7:0] : 8'h00;
      6'h0B: next_byte = (state == ST_CHIP) ? pid[15:8] : 8'h00;
      6'h0C: next_byte = (state == ST_CHIP) ? attr : 8'h00;
      6'h0D: next_byte = (state == ST_CHIP) ? ma : 8'h00;
      default: next_byte = 8'h00;
    endcase
  end

  wire start_chip = wr && avs_address_in == `PUSR_CTRL_ADDR && avs_byteenable_in[0]
    && avs_writedata_in[`PUSR_CTRL_CHIP_BIT];
  wire start_gp = wr && avs_address_in == `PUSR_CTRL_ADDR && avs_byteenable_in[0]
    && avs_writedata_in[`PUSR_CTRL_GP_BIT];
  assign done_evt = (state != ST_IDLE) && idx == `PUSR_RESP_LAST;

  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      state <= ST_IDLE;
      idx <= 6'h00;
      resp_byte_out <= 8'h00;
      resp_index_out <= 6'h00;
      resp_valid_out <= 1'b0;
      resp_last_out <= 1'b0;
    end else begin
      resp_valid_out <= state != ST_IDLE;
      resp_byte_out <= (state != ST_IDLE) ? next_byte : 8'h00;
      resp_index_out <= idx;
      resp_last_out <= done_evt;
      case (state)
        ST_IDLE: begin
          idx <= 6'h00;
          // chip reply wins if both are requested; the other is dropped
          if (start_chip) begin
            state <= ST_CHIP;
          end else if (start_gp) begin
            state <= ST_GP;
          end
        end
        ST_CHIP, ST_GP: begin
          idx <= idx + 6'h01;
          if (done_evt) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // pusr_settings_readback
